// ### core/sbp_pkg.sv
// Package: states, carriers and timing constants of the start-up supervisor
package sbp_pkg;
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned LINE_LOW_BLANKING_MS = 50;
   localparam int unsigned MAINS_LOSS_TIMEOUT_MS = 100;
   localparam int unsigned REMOTE_CLAMP_MS = 100;
   localparam int unsigned SOFT_START_MS = 4;
   localparam int unsigned SUPPLY_GROUND_US = 100;
   localparam int unsigned LINE_LOW_BLANKING_CYC = LINE_LOW_BLANKING_MS * (CLK_HZ / 1000);
   localparam int unsigned MAINS_LOSS_TIMEOUT_CYC = MAINS_LOSS_TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int unsigned REMOTE_CLAMP_CYC = REMOTE_CLAMP_MS * (CLK_HZ / 1000);
   localparam int unsigned SOFT_START_CYC = SOFT_START_MS * (CLK_HZ / 1000);
   localparam int unsigned SUPPLY_GROUND_CYC = SUPPLY_GROUND_US * (CLK_HZ / 1000_000);
   localparam int unsigned CNT_W = 24;

   // Start-up current source level
   typedef enum logic [1:0] {
      SBP_SRC_OFF = 2'h0,
      SBP_SRC_LOW = 2'h1,
      SBP_SRC_FULL = 2'h2
   } sbp_src_t;

   // Sequencer states, Gray along the start-up path
   typedef enum logic [3:0] {
      SBP_ST_CHARGE = 4'h0,
      SBP_ST_SOFT = 4'h1,
      SBP_ST_RUN = 4'h3,
      SBP_ST_BO_STOP = 4'h2,
      SBP_ST_GROUND = 4'h6,
      SBP_ST_RECHARGE = 4'h7,
      SBP_ST_OFF = 4'h5,
      SBP_ST_PAUSE = 4'h4,
      SBP_ST_DISCHARGE = 4'hc
   } sbp_state_t;

   // Comparator outcomes
   typedef struct packed {
      logic line_above_low;
      logic line_above_recover;
      logic supply_above_guard;
      logic supply_at_startup;
      logic supply_above_hold;
      logic mains_absent;
      logic over_temp;
      logic remote_above_off;
      logic remote_below_restart;
   } sbp_sense_t;

   // Actuator commands
   typedef struct packed {
      logic gate_enable;
      logic soft_start;
      sbp_src_t src_level;
      logic supply_ground;
      logic filter_discharge;
      logic remote_pulldown;
      logic general_reset;
   } sbp_ctrl_t;
endpackage

// ### core/sbp_supervisor.sv
// Module: start-up, brown-out, mains-loss and power-savings sequencer
`timescale 1ns/10ps

// Function
// R1: Line low for blanking: stop, hold bias
// R2: Line recovery: ground supply, fresh start
// R3: Recovery recharge uses full current always
// R4: Brown-out during charge pauses without grounding
// R5: Low current while supply below guard
// R6: Full current above guard level
// R7: Source off at start-up level, run
// R8: Mains absence must persist full timeout
// R9: Timeout expiry: ground supply, enable source
// R10: Mains monitoring active in off, start-up
// R11: Over-temperature stops filter discharge
// R12: Remote above off level enters off
// R13: Off mode disables all except monitoring
// R14: Remote at restart level: fresh start-up
// R15: Self-relaxing off cycle repeats while released
// R16: Remote pulled low at non-relaxing restarts
// R17: Secondary holds remote low normally
// R18: Line recovery issues general reset pulse
// R19: Every start-up begins with soft-start
// R20: Inputs synchronous, timing from clock
// R21: No off during brown-out; discharge first
module sbp_supervisor #(
   parameter int unsigned LINE_LOW_BLANKING = sbp_pkg::LINE_LOW_BLANKING_CYC,
   parameter int unsigned MAINS_LOSS_TIMEOUT = sbp_pkg::MAINS_LOSS_TIMEOUT_CYC,
   parameter int unsigned REMOTE_CLAMP = sbp_pkg::REMOTE_CLAMP_CYC,
   parameter int unsigned SOFT_START = sbp_pkg::SOFT_START_CYC,
   parameter int unsigned SUPPLY_GROUND = sbp_pkg::SUPPLY_GROUND_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Comparator outcomes
   input wire sbp_pkg::sbp_sense_t sense,
   // Actuator commands
   output sbp_pkg::sbp_ctrl_t ctrl,
   output sbp_pkg::sbp_state_t state
);
   // Every interval must fit the shared counter width, so the build is refused otherwise
   if (LINE_LOW_BLANKING < 1 || LINE_LOW_BLANKING >= (1 << sbp_pkg::CNT_W) ||
       MAINS_LOSS_TIMEOUT < 1 || MAINS_LOSS_TIMEOUT >= (1 << sbp_pkg::CNT_W) ||
       REMOTE_CLAMP < 1 || REMOTE_CLAMP >= (1 << sbp_pkg::CNT_W) ||
       SOFT_START < 1 || SOFT_START >= (1 << sbp_pkg::CNT_W) ||
       SUPPLY_GROUND < 1 || SUPPLY_GROUND >= (1 << sbp_pkg::CNT_W)) begin : g_bad_timing
      $error("sbp_supervisor: timing parameter out of counter range");
   end

   localparam logic [sbp_pkg::CNT_W-1:0] BLANK_N = sbp_pkg::CNT_W'(LINE_LOW_BLANKING);
   localparam logic [sbp_pkg::CNT_W-1:0] MAINS_N = sbp_pkg::CNT_W'(MAINS_LOSS_TIMEOUT);
   localparam logic [sbp_pkg::CNT_W-1:0] CLAMP_N = sbp_pkg::CNT_W'(REMOTE_CLAMP);
   localparam logic [sbp_pkg::CNT_W-1:0] SOFT_N = sbp_pkg::CNT_W'(SOFT_START);
   localparam logic [sbp_pkg::CNT_W-1:0] GROUND_N = sbp_pkg::CNT_W'(SUPPLY_GROUND);

   // Whole module state
   typedef struct packed {
      sbp_pkg::sbp_state_t st;
      logic [sbp_pkg::CNT_W-1:0] blank_cnt;
      logic [sbp_pkg::CNT_W-1:0] mains_cnt;
      logic [sbp_pkg::CNT_W-1:0] clamp_cnt;
      logic [sbp_pkg::CNT_W-1:0] seq_cnt;
      logic relaxing;
      logic line_low;
      sbp_pkg::sbp_ctrl_t out;
   } sbp_regs_t;

   sbp_regs_t s_reg;
   sbp_regs_t s_next;

   logic line_low_now;
   logic mains_lost;
   logic [sbp_pkg::CNT_W-1:0] one;

   assign one = sbp_pkg::CNT_W'(1);
   // Inputs are already synchronous, so they are used directly
   assign line_low_now = !sense.line_above_low; // R20
   // Mains loss confirmed only after the full timeout
   assign mains_lost = (s_reg.mains_cnt == MAINS_N); // R8

   // Next-state logic
   always_comb begin
      s_next = s_reg;
      s_next.out.general_reset = 1'b0;

      // Line-low blanking: a short dip resets the count
      if (!line_low_now) begin
         s_next.blank_cnt = '0;
         s_next.line_low = 1'b0;
      end else if (s_reg.blank_cnt == BLANK_N) begin
         s_next.line_low = 1'b1; // R1
      end else begin
         s_next.blank_cnt = s_reg.blank_cnt + one; // R1
      end
      // Line low flag clears only once above the recovery level
      if (s_reg.line_low && !sense.line_above_recover && line_low_now == 1'b0) begin
         s_next.line_low = 1'b1;
      end

      // Mains-loss timer runs in every state
      if (!sense.mains_absent) begin
         s_next.mains_cnt = '0; // R8
      end else if (s_reg.mains_cnt != MAINS_N) begin
         s_next.mains_cnt = s_reg.mains_cnt + one; // R10
      end

      // Remote clamp timer
      if (s_reg.clamp_cnt != '0) begin
         s_next.clamp_cnt = s_reg.clamp_cnt - one; // R16
      end

      case (s_reg.st)
         sbp_pkg::SBP_ST_CHARGE: begin
            if (s_reg.line_low) begin
               s_next.st = sbp_pkg::SBP_ST_PAUSE; // R4
            end else if (sense.supply_at_startup) begin
               s_next.st = sbp_pkg::SBP_ST_SOFT; // R7
               s_next.seq_cnt = '0;
            end
         end
         sbp_pkg::SBP_ST_PAUSE: begin
            // Supply is not grounded; charging resumes on recovery
            if (sense.line_above_recover) begin
               s_next.st = sbp_pkg::SBP_ST_CHARGE; // R4
               s_next.line_low = 1'b0;
            end
         end
         sbp_pkg::SBP_ST_SOFT: begin
            if (s_reg.line_low) begin
               s_next.st = sbp_pkg::SBP_ST_BO_STOP; // R1
            end else if (s_reg.seq_cnt == SOFT_N - one) begin
               s_next.st = sbp_pkg::SBP_ST_RUN; // R19
            end else begin
               s_next.seq_cnt = s_reg.seq_cnt + one; // R19
            end
         end
         sbp_pkg::SBP_ST_RUN: begin
            if (s_reg.line_low) begin
               s_next.st = sbp_pkg::SBP_ST_BO_STOP; // R1
            end else if (sense.remote_above_off) begin
               s_next.st = sbp_pkg::SBP_ST_OFF; // R12
            end else begin
               s_next.relaxing = 1'b0; // R15
            end
         end
         sbp_pkg::SBP_ST_BO_STOP: begin
            if (sense.line_above_recover) begin
               s_next.st = sbp_pkg::SBP_ST_GROUND; // R2
               s_next.seq_cnt = '0;
               s_next.line_low = 1'b0;
               s_next.out.general_reset = 1'b1; // R18
            end
         end
         sbp_pkg::SBP_ST_GROUND: begin
            if (s_reg.seq_cnt == GROUND_N - one) begin
               s_next.st = sbp_pkg::SBP_ST_RECHARGE; // R2
            end else begin
               s_next.seq_cnt = s_reg.seq_cnt + one;
            end
         end
         sbp_pkg::SBP_ST_RECHARGE: begin
            if (s_reg.line_low) begin
               s_next.st = sbp_pkg::SBP_ST_BO_STOP; // R1
            end else if (sense.supply_at_startup) begin
               s_next.st = sbp_pkg::SBP_ST_SOFT; // R19
               s_next.seq_cnt = '0;
            end
         end
         sbp_pkg::SBP_ST_OFF: begin
            if (sense.remote_below_restart) begin
               s_next.st = sbp_pkg::SBP_ST_CHARGE; // R14
               s_next.relaxing = 1'b1; // R15
            end
         end
         sbp_pkg::SBP_ST_DISCHARGE: begin
            // Only a return of the mains ends the discharge
            if (!sense.mains_absent) begin
               s_next.st = sbp_pkg::SBP_ST_CHARGE;
               s_next.relaxing = 1'b0;
            end
         end
         default: begin
            s_next.st = sbp_pkg::SBP_ST_CHARGE;
         end
      endcase

      // Restarts other than the self-relaxing one clamp the remote pin
      if (s_next.st == sbp_pkg::SBP_ST_SOFT && s_reg.st != sbp_pkg::SBP_ST_SOFT && !s_next.relaxing) begin
         s_next.clamp_cnt = CLAMP_N; // R16
      end

      // Confirmed mains loss overrides every state
      if (mains_lost) begin
         s_next.st = sbp_pkg::SBP_ST_DISCHARGE; // R21
      end

      // Outputs follow the next state
      s_next.out.gate_enable = (s_next.st == sbp_pkg::SBP_ST_SOFT) || (s_next.st == sbp_pkg::SBP_ST_RUN);
      s_next.out.soft_start = (s_next.st == sbp_pkg::SBP_ST_SOFT); // R19
      s_next.out.supply_ground = (s_next.st == sbp_pkg::SBP_ST_GROUND) ||
                                 (s_next.st == sbp_pkg::SBP_ST_DISCHARGE && !sense.over_temp); // R9
      s_next.out.filter_discharge = (s_next.st == sbp_pkg::SBP_ST_DISCHARGE) && !sense.over_temp; // R11
      s_next.out.remote_pulldown = (s_next.clamp_cnt != '0); // R16
      case (s_next.st)
         sbp_pkg::SBP_ST_CHARGE: begin
            s_next.out.src_level = sense.supply_above_guard ? sbp_pkg::SBP_SRC_FULL : sbp_pkg::SBP_SRC_LOW; // R5 R6
         end
         sbp_pkg::SBP_ST_RECHARGE: begin
            s_next.out.src_level = sbp_pkg::SBP_SRC_FULL; // R3
         end
         sbp_pkg::SBP_ST_BO_STOP: begin
            // Hold the supply at its bias level
            s_next.out.src_level = sense.supply_above_hold ? sbp_pkg::SBP_SRC_OFF : sbp_pkg::SBP_SRC_FULL; // R1
         end
         sbp_pkg::SBP_ST_DISCHARGE: begin
            s_next.out.src_level = sense.over_temp ? sbp_pkg::SBP_SRC_OFF : sbp_pkg::SBP_SRC_FULL; // R9 R11
         end
         default: begin
            // Source off in run, soft-start, pause, ground and off
            s_next.out.src_level = sbp_pkg::SBP_SRC_OFF; // R7 R13
         end
      endcase
   end

   // State register
   always_ff @(posedge clk) begin
      if (reset) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign ctrl = s_reg.out;
   assign state = s_reg.st;

   // A confirmed mains loss wins over every other state
   chk_discharge_wins: assert property (@(posedge clk) disable iff (reset) // R21
      (s_reg.mains_cnt == MAINS_N) |=> state == sbp_pkg::SBP_ST_DISCHARGE)
      else $error("mains loss did not force discharge");

   // Discharge is entered only from a count that ran the full timeout
   chk_short_dip_ignored: assert property (@(posedge clk) disable iff (reset) // R8
      state != sbp_pkg::SBP_ST_DISCHARGE ##1 state == sbp_pkg::SBP_ST_DISCHARGE |->
      $past(s_reg.mains_cnt) == MAINS_N)
      else $error("discharge started without timeout");

   // Any return of the mains restarts the loss timer from zero
   chk_dropout_clears: assert property (@(posedge clk) disable iff (reset) // R8
      !sense.mains_absent |=> s_reg.mains_cnt == '0)
      else $error("mains dropout did not clear the timer");

   // A hot junction must already have stopped the drain
   chk_discharge_temp: assert property (@(posedge clk) disable iff (reset) // R11
      ctrl.filter_discharge |-> $past(!sense.over_temp))
      else $error("discharge ran while over temperature");

   // A cool junction: ground switch closed and source at full current
   chk_discharge_source: assert property (@(posedge clk) disable iff (reset) // R9
      state == sbp_pkg::SBP_ST_DISCHARGE && !$past(sense.over_temp) |->
      ctrl.supply_ground && ctrl.src_level == sbp_pkg::SBP_SRC_FULL)
      else $error("discharge switch or source not on");

   // No gate drive while stopped on a low line
   chk_no_gate_bo: assert property (@(posedge clk) disable iff (reset) // R1
      state == sbp_pkg::SBP_ST_BO_STOP |-> !ctrl.gate_enable)
      else $error("gate drive during brown-out stop");

   // Gate drive only in soft-start and run, never in off or any stop
   chk_gate_states: assert property (@(posedge clk) disable iff (reset) // R13
      ctrl.gate_enable |-> state == sbp_pkg::SBP_ST_SOFT || state == sbp_pkg::SBP_ST_RUN)
      else $error("gate drive outside soft-start or run");

   // One general reset pulse as the recovery grounding begins
   chk_recover_reset: assert property (@(posedge clk) disable iff (reset) // R18
      state == sbp_pkg::SBP_ST_BO_STOP ##1 state == sbp_pkg::SBP_ST_GROUND |->
      ctrl.general_reset ##1 !ctrl.general_reset)
      else $error("no single reset pulse on recovery");

   // Recovery grounds the supply with the gate off
   chk_ground_recover: assert property (@(posedge clk) disable iff (reset) // R2
      state == sbp_pkg::SBP_ST_GROUND |-> ctrl.supply_ground && !ctrl.gate_enable)
      else $error("supply not grounded on recovery");

   // Recovery recharge never drops to the reduced current
   chk_recharge_full: assert property (@(posedge clk) disable iff (reset) // R3
      state == sbp_pkg::SBP_ST_RECHARGE |-> ctrl.src_level == sbp_pkg::SBP_SRC_FULL)
      else $error("recovery recharge not at full current");

   // A paused charge keeps the supply where it is
   chk_pause_no_ground: assert property (@(posedge clk) disable iff (reset) // R4
      state == sbp_pkg::SBP_ST_PAUSE |-> !ctrl.supply_ground && !ctrl.gate_enable)
      else $error("pause grounded the supply");

   // The pause ends as soon as the line is back
   chk_pause_resume: assert property (@(posedge clk) disable iff (reset) // R4
      state == sbp_pkg::SBP_ST_PAUSE && sense.line_above_recover && !mains_lost |=>
      state == sbp_pkg::SBP_ST_CHARGE)
      else $error("charge did not resume after line recovery");

   // The first cycle after reset still shows reset outputs, hence the past-reset guard
   chk_low_current_guard: assert property (@(posedge clk) disable iff (reset) // R5
      !$past(reset) && state == sbp_pkg::SBP_ST_CHARGE && !$past(sense.supply_above_guard) |->
      ctrl.src_level == sbp_pkg::SBP_SRC_LOW)
      else $error("reduced current not used below guard level");

   // Above the guard level the charge runs at full current
   chk_full_current_guard: assert property (@(posedge clk) disable iff (reset) // R6
      !$past(reset) && state == sbp_pkg::SBP_ST_CHARGE && $past(sense.supply_above_guard) |->
      ctrl.src_level == sbp_pkg::SBP_SRC_FULL)
      else $error("full current not used above guard level");

   // Soft-start only follows a supply that reached the start-up level
   chk_soft_needs_supply: assert property (@(posedge clk) disable iff (reset) // R7
      $rose(state == sbp_pkg::SBP_ST_SOFT) |-> $past(sense.supply_at_startup))
      else $error("start-up began below the start-up level");

   // Once switching, the start-up source stays off
   chk_run_source_off: assert property (@(posedge clk) disable iff (reset) // R7
      state == sbp_pkg::SBP_ST_SOFT || state == sbp_pkg::SBP_ST_RUN |->
      ctrl.src_level == sbp_pkg::SBP_SRC_OFF)
      else $error("start-up source on while switching");

   // Soft-start flag marks the whole soft-start interval
   chk_soft_flag: assert property (@(posedge clk) disable iff (reset) // R19
      state == sbp_pkg::SBP_ST_SOFT |-> ctrl.soft_start)
      else $error("soft-start flag missing");

   // Run is only reached through soft-start
   chk_soft_first: assert property (@(posedge clk) disable iff (reset) // R19
      $rose(state == sbp_pkg::SBP_ST_RUN) |-> $past(state) == sbp_pkg::SBP_ST_SOFT)
      else $error("run entered without soft-start");

   // Off mode is entered from run on a released remote pin only
   chk_off_from_run: assert property (@(posedge clk) disable iff (reset) // R12
      $rose(state == sbp_pkg::SBP_ST_OFF) |->
      $past(state) == sbp_pkg::SBP_ST_RUN && $past(sense.remote_above_off))
      else $error("off mode entered without remote request");

   // Off mode leaves nothing running but the mains watch
   chk_off_quiet: assert property (@(posedge clk) disable iff (reset) // R13
      state == sbp_pkg::SBP_ST_OFF |-> !ctrl.gate_enable && ctrl.src_level == sbp_pkg::SBP_SRC_OFF)
      else $error("off mode not quiet");

   // A remote pin at the restart level starts a fresh charge
   chk_off_restart: assert property (@(posedge clk) disable iff (reset) // R14
      state == sbp_pkg::SBP_ST_OFF && sense.remote_below_restart && !mains_lost |=>
      state == sbp_pkg::SBP_ST_CHARGE)
      else $error("off mode did not restart");

   // Ordinary restarts clamp the remote pin from the first soft-start cycle
   chk_restart_clamp: assert property (@(posedge clk) disable iff (reset) // R16
      $rose(state == sbp_pkg::SBP_ST_SOFT) && !s_reg.relaxing |-> ctrl.remote_pulldown)
      else $error("remote pin not clamped at restart");

   // The self-relaxing restart leaves the remote pin free to swing
   chk_relax_no_clamp: assert property (@(posedge clk) disable iff (reset) // R15
      $rose(state == sbp_pkg::SBP_ST_SOFT) && s_reg.relaxing && !$past(ctrl.remote_pulldown) |->
      !ctrl.remote_pulldown)
      else $error("remote pin clamped in relaxing restart");
endmodule

// ### bench/sbp_far_side.sv
// Far-side model: secondary-side optocoupler and the network on the remote pin
`timescale 1ns/10ps
module sbp_far_side #(
   parameter int OFF_LVL = 8,
   parameter int RESTART_LVL = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Secondary request and device outputs
   input wire logic release_opto,
   input wire logic pin_clamp,
   input wire logic switching,
   // Remote pin comparator view
   output logic above_off,
   output logic below_restart
);
   int lvl_reg;

   // Pin voltage: the opto or the device clamp grounds it, aux winding lifts it only while switching
   always_ff @(posedge clk) begin
      if (reset || !release_opto || pin_clamp) begin
         lvl_reg <= 0;
      end else if (switching) begin
         lvl_reg <= (lvl_reg <= OFF_LVL) ? lvl_reg + 1 : lvl_reg;
      end else if (lvl_reg > 0) begin
         lvl_reg <= lvl_reg - 1; // Supply gone: pin decays slowly
      end
   end

   // Comparator outcomes
   assign above_off = (lvl_reg >= OFF_LVL);
   assign below_restart = (lvl_reg <= RESTART_LVL);
endmodule

// ### bench/sbp_supervisor_tb_top.sv
// Testbench: start-up, brown-out, power-savings and mains-loss sequences
`timescale 1ns/10ps
module sbp_supervisor_tb_top;
   localparam int LLB = 8;
   localparam int MLT = 10;
   localparam int RCL = 12;
   localparam int SST = 6;
   localparam int SGD = 3;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic release_opto = 1'b0;
   logic line_lo, line_rec, guard, at_start, hold, mains_abs, hot;
   logic above_off, below_restart;
   sbp_pkg::sbp_sense_t sense;
   sbp_pkg::sbp_ctrl_t ctrl;
   sbp_pkg::sbp_state_t state;
   int num_errors = 0;
   int cmp_count = 0;
   int n;

   // 50 MHz clock
   always #10 clk = ~clk;

   assign sense = {line_lo, line_rec, guard, at_start, hold, mains_abs, hot, above_off, below_restart};

   sbp_supervisor #(.LINE_LOW_BLANKING(LLB), .MAINS_LOSS_TIMEOUT(MLT), .REMOTE_CLAMP(RCL),
      .SOFT_START(SST), .SUPPLY_GROUND(SGD)) uut (.clk(clk), .reset(reset), .sense(sense),
      .ctrl(ctrl), .state(state));

   sbp_far_side far (.clk(clk), .reset(reset), .release_opto(release_opto),
      .pin_clamp(ctrl.remote_pulldown), .switching(ctrl.gate_enable), .above_off(above_off),
      .below_restart(below_restart));

   task automatic finish_test;
      $display("Mismatches %0d, comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Inputs move 1 ns after the edge, so registered outputs are settled there
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic chk_state(input string what, input sbp_pkg::sbp_state_t exp);
      cmp_count++;
      if (state !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, state);
      end
   endtask

   task automatic chk_v(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Bounded wait for a state; cyc counts the edges it took
   task automatic wait_for(input sbp_pkg::sbp_state_t st, input int max, output int cyc);
      cyc = 0;
      while (state !== st) begin
         step(1);
         cyc++;
         if (cyc > max) begin
            num_errors++;
            $display("[FAIL] wait for state expected %h seen %h", st, state);
            finish_test();
         end
      end
   endtask

   initial begin
      void'($urandom(97));
      {line_lo, line_rec, guard, at_start, hold, mains_abs, hot} = 7'b1100100;
      step(2);
      chk_state("state in reset", sbp_pkg::SBP_ST_CHARGE);
      chk_v("ctrl in reset", 8'h00, ctrl);
      reset = 1'b0;
      step(1);
      chk_v("low current", sbp_pkg::SBP_SRC_LOW, ctrl.src_level);
      guard = 1'b1;
      step(1);
      chk_v("full current", sbp_pkg::SBP_SRC_FULL, ctrl.src_level);
      at_start = 1'b1;
      wait_for(sbp_pkg::SBP_ST_SOFT, 2, n);
      chk_v("source off", sbp_pkg::SBP_SRC_OFF, ctrl.src_level);
      chk_v("soft and gate", 8'h03, {ctrl.gate_enable, ctrl.soft_start});
      wait_for(sbp_pkg::SBP_ST_RUN, SST + 2, n);
      chk_v("soft length", 8'h01, (n >= SST - 1 && n <= SST + 1));
      step(RCL - 2 - n);
      chk_v("clamp held", 8'h01, ctrl.remote_pulldown);
      step(4);
      chk_v("clamp released", 8'h00, ctrl.remote_pulldown);
      // Short line dip, then a real brown-out
      {line_lo, line_rec} = 2'b00;
      step($urandom_range(LLB - 2, 1));
      {line_lo, line_rec} = 2'b10;
      step(2);
      chk_state("short dip ignored", sbp_pkg::SBP_ST_RUN);
      line_lo = 1'b0;
      wait_for(sbp_pkg::SBP_ST_BO_STOP, LLB + 3, n);
      chk_v("blanking length", 8'h01, (n >= LLB - 1));
      chk_v("bias hold", 8'h00, {ctrl.gate_enable, ctrl.src_level != sbp_pkg::SBP_SRC_OFF});
      hold = 1'b0;
      step(1);
      chk_v("bias recharge", sbp_pkg::SBP_SRC_FULL, ctrl.src_level);
      {at_start, guard} = 2'b00;
      {line_lo, line_rec} = 2'b11;
      step(1);
      chk_state("recovery ground", sbp_pkg::SBP_ST_GROUND);
      chk_v("ground and reset", 8'h03, {ctrl.supply_ground, ctrl.general_reset});
      step(1);
      chk_v("reset pulse", 8'h00, ctrl.general_reset);
      wait_for(sbp_pkg::SBP_ST_RECHARGE, SGD + 2, n);
      chk_v("recharge current", sbp_pkg::SBP_SRC_FULL, ctrl.src_level);
      at_start = 1'b1;
      wait_for(sbp_pkg::SBP_ST_SOFT, 2, n);
      chk_v("restart clamp", 8'h01, ctrl.remote_pulldown);
      wait_for(sbp_pkg::SBP_ST_RUN, SST + 2, n);
      step(RCL);
      // Power-savings: opto released
      release_opto = 1'b1;
      wait_for(sbp_pkg::SBP_ST_OFF, 15, n);
      chk_v("off outputs", 8'h00, {ctrl.gate_enable, ctrl.src_level, ctrl.remote_pulldown});
      {at_start, guard} = 2'b00;
      wait_for(sbp_pkg::SBP_ST_CHARGE, 15, n);
      {at_start, guard} = 2'b11;
      wait_for(sbp_pkg::SBP_ST_SOFT, 2, n);
      chk_v("relaxing no clamp", 8'h00, ctrl.remote_pulldown);
      wait_for(sbp_pkg::SBP_ST_OFF, SST + 15, n);
      release_opto = 1'b0;
      at_start = 1'b0;
      wait_for(sbp_pkg::SBP_ST_CHARGE, 15, n);
      at_start = 1'b1;
      wait_for(sbp_pkg::SBP_ST_RUN, SST + 4, n);
      step(RCL + 8);
      chk_state("opto held stays on", sbp_pkg::SBP_ST_RUN);
      // Mains loss: short dropout, then the real one
      mains_abs = 1'b1;
      step($urandom_range(MLT - 2, 2));
      mains_abs = 1'b0;
      step(2);
      chk_state("dropout ignored", sbp_pkg::SBP_ST_RUN);
      mains_abs = 1'b1;
      wait_for(sbp_pkg::SBP_ST_DISCHARGE, MLT + 3, n);
      chk_v("timeout length", 8'h01, (n >= MLT - 1));
      chk_v("discharge", 8'h03, {ctrl.gate_enable, ctrl.filter_discharge, ctrl.supply_ground});
      chk_v("discharge source", 8'h01, (ctrl.src_level != sbp_pkg::SBP_SRC_OFF));
      hot = 1'b1;
      step(1);
      chk_v("hot stop", 8'h00, {ctrl.supply_ground, ctrl.src_level});
      {hot, mains_abs, at_start} = 3'b000;
      wait_for(sbp_pkg::SBP_ST_CHARGE, 3, n);
      // Brown-out during charge pauses without grounding
      {line_lo, line_rec} = 2'b00;
      wait_for(sbp_pkg::SBP_ST_PAUSE, LLB + 3, n);
      chk_v("pause no ground", 8'h00, ctrl.supply_ground);
      {line_lo, line_rec} = 2'b11;
      wait_for(sbp_pkg::SBP_ST_CHARGE, 3, n);
      mains_abs = 1'b1;
      wait_for(sbp_pkg::SBP_ST_DISCHARGE, MLT + 3, n);
      finish_test();
   end
endmodule
